// file: design/sfw_defs.svh
`ifndef SFW_DEFS_SVH
`define SFW_DEFS_SVH

// ********************************************************************
// Opcodes seen by this block
// ********************************************************************
`define SFW_OP_SET_WL 8'h06
`define SFW_OP_CLR_WL 8'h04
`define SFW_OP_RD_STAT 8'h05
`define SFW_OP_RD_SUSP 8'h09

// ********************************************************************
// Status byte bit positions
// ********************************************************************
`define SFW_SR_BUSY 0
`define SFW_SR_WEL 1
`define SFW_SR_BP_LO 2
`define SFW_SR_BP_HI 5
`define SFW_SR_PROTECT_PINS_DISABLE_BIT 6
`define SFW_SR_LOCK 7

// ********************************************************************
// Suspend status byte bit positions
// ********************************************************************
`define SFW_SS_WEL 1
`define SFW_SS_ERS 2
`define SFW_SS_PRS 3
`define SFW_SS_FAIL 5
`define SFW_SS_BUSY 7

// ********************************************************************
// Held protection bits: {otp lock, status lock, pin disable, level[3:0]}
// ********************************************************************
`define SFW_NV_OTP 6
`define SFW_NV_SRP 5
`define SFW_NV_PROTECT_PINS_DISABLE_BIT 4
`define SFW_NV_RST 7'h00

`endif

// file: design/sfw_pkg.sv
// ********************************************************************
// Shared types
// ********************************************************************
package sfw_pkg;

    // Kind of write-type command offered for approval
    typedef enum logic [2:0] {
        SFW_WK_STATUS = 3'b000,
        SFW_WK_PAGE = 3'b001,
        SFW_WK_SECTOR = 3'b010,
        SFW_WK_HALF = 3'b011,
        SFW_WK_BLOCK = 3'b100,
        SFW_WK_CHIP = 3'b101,
        SFW_WK_QPAGE = 3'b110
    } sfw_wr_kind_t;

endpackage

// file: design/sfw_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Two-flop level synchroniser, one chain per bit
// ********************************************************************
module sfw_sync2
    import sfw_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_q; // First stage, read only by sync_q
            logic sync_q; // Safe stage
            // Plain two-stage chain
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= i_d[g];
                    sync_q <= meta_q;
                end
            end
            assign o_q[g] = sync_q;
        end
    endgenerate

endmodule

`default_nettype wire

// file: design/sfw_link_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfw_defs.svh"

// ********************************************************************
// Link-side opcode capture and status shift-out
// ********************************************************************
module sfw_link_shift
    import sfw_pkg::*;
(
    input wire logic i_link_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic [3:0] i_dq_in,
    input wire logic i_quad_mode,
    input wire logic i_snap_req,
    input wire logic [7:0] i_hold_status,
    input wire logic [7:0] i_hold_suspend,
    output logic o_op_tgl,
    output logic [7:0] o_opcode,
    output logic o_snap_ack,
    output logic [3:0] o_dq_out,
    output logic [3:0] o_dq_oe
);

    logic frame_rst; // Frame state dies with chip select
    logic [1:0] xs; // {quad mode, snapshot request} synced
    logic [2:0] bit_cnt_q;
    logic [7:0] in_sh_q;
    logic op_done_q;
    logic [7:0] snap_stat_q;
    logic [7:0] snap_susp_q;
    logic [2:0] out_cnt_q;
    logic [7:0] out_sh_q;
    logic [7:0] byte_nx;
    logic last_bit;
    logic take_op;
    logic rd_stat;
    logic rd_susp;
    logic [7:0] out_src;

    assign frame_rst = i_rst | i_cs_n;

    sfw_sync2 #(.W(2)) u_sync (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_d({i_quad_mode, i_snap_req}),
        .o_q(xs)
    );

    // Four bits per edge in quad form, one otherwise
    assign byte_nx = xs[1] ? {in_sh_q[3:0], i_dq_in} : {in_sh_q[6:0], i_dq_in[0]};
    assign last_bit = xs[1] ? (bit_cnt_q == 3'h1) : (bit_cnt_q == 3'h7);
    assign take_op = ~op_done_q & last_bit;

    // Opcode shifter, cleared whenever the frame closes
    always_ff @(posedge i_link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_q <= 3'h0;
            in_sh_q <= 8'h00;
            op_done_q <= 1'b0;
        end else if (!op_done_q) begin
            in_sh_q <= byte_nx;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            op_done_q <= last_bit;
        end
    end

    // Opcode survives the frame end; only a full byte toggles
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            o_opcode <= 8'h00;
            o_op_tgl <= 1'b0;
        end else if (take_op) begin
            o_opcode <= byte_nx;
            o_op_tgl <= ~o_op_tgl;
        end
    end

    // Status words cross by request/acknowledge toggles
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            snap_stat_q <= 8'h00;
            snap_susp_q <= 8'h00;
            o_snap_ack <= 1'b0;
        end else if (xs[0] != o_snap_ack) begin
            snap_stat_q <= i_hold_status;
            snap_susp_q <= i_hold_suspend;
            o_snap_ack <= xs[0];
        end
    end

    assign rd_stat = op_done_q & (o_opcode == `SFW_OP_RD_STAT);
    assign rd_susp = op_done_q & (o_opcode == `SFW_OP_RD_SUSP);
    // Fresh snapshot at every byte boundary, so polling sees updates
    assign out_src = (out_cnt_q == 3'h0) ? (rd_susp ? snap_susp_q : snap_stat_q) : out_sh_q;

    // Output on falling edges, MSB first, repeating while selected
    always_ff @(negedge i_link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            o_dq_out <= 4'h0;
            o_dq_oe <= 4'h0;
            out_cnt_q <= 3'h0;
            out_sh_q <= 8'h00;
        end else if (rd_stat | rd_susp) begin
            if (xs[1]) begin
                o_dq_out <= out_src[7:4];
                o_dq_oe <= 4'hf;
                out_sh_q <= {out_src[3:0], 4'h0};
                out_cnt_q <= (out_cnt_q == 3'h1) ? 3'h0 : 3'h1;
            end else begin
                o_dq_out <= {2'b00, out_src[7], 1'b0};
                o_dq_oe <= 4'h2;
                out_sh_q <= {out_src[6:0], 1'b0};
                out_cnt_q <= out_cnt_q + 3'h1;
            end
        end
    end

endmodule

`default_nettype wire

// file: design/sfw_write_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfw_defs.svh"

module sfw_write_status
    import sfw_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Link pins
    input wire logic i_link_clk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_dq_in,
    output logic [3:0] o_dq_out,
    output logic [3:0] o_dq_oe,
    input wire logic i_wp_n,
    input wire logic i_hold_n,
    // Neighbour blocks, same clock
    input wire logic i_quad_mode,
    input wire logic i_otp_enter,
    input wire logic i_soft_rst,
    input wire logic i_nv_load,
    input wire logic [6:0] i_nv_bits,
    input wire logic i_wr_req,
    input wire logic [2:0] i_wr_kind,
    input wire logic [7:0] i_wr_data,
    input wire logic i_target_protected,
    input wire logic i_op_done,
    input wire logic i_op_fail,
    input wire logic i_susp_cycle,
    input wire logic i_erase_susp,
    input wire logic i_erase_resume,
    input wire logic i_prog_susp,
    input wire logic i_prog_resume,
    // Results
    output logic o_wr_grant,
    output logic o_wr_reject,
    output logic o_nv_store,
    output logic [6:0] o_nv_bits,
    output logic [7:0] o_status_byte,
    output logic [7:0] o_suspend_byte,
    output logic o_otp_mode,
    output logic o_hw_protect,
    output logic o_hold_n_eff
);

    // ****************************************************************
    // Crossing from the link and the pins
    // ****************************************************************
    logic [4:0] sy; // {cs_n, wp_n, hold_n, op toggle, snap ack}
    logic link_op_tgl; // Opcode toggle, link domain
    logic [7:0] link_opcode; // Held until the next full opcode
    logic link_snap_ack; // Snapshot acknowledge, link domain
    logic cs_s; // Synced chip select, high = idle
    logic wp_s; // Synced protect pin
    logic hold_s; // Synced hold pin
    logic op_s; // Synced opcode toggle
    logic ack_s; // Synced snapshot acknowledge

    sfw_sync2 #(.W(5)) u_sync (
        .i_clk(i_sys_clk),
        .i_rst(i_sys_rst),
        .i_d({i_cs_n, i_wp_n, i_hold_n, link_op_tgl, link_snap_ack}),
        .o_q(sy)
    );

    assign cs_s = sy[4];
    assign wp_s = sy[3];
    assign hold_s = sy[2];
    assign op_s = sy[1];
    assign ack_s = sy[0];

    // ****************************************************************
    // Held state
    // ****************************************************************
    logic wel_q; // Write latch
    logic busy_q; // Program, erase or status write running
    logic fail_q; // Last operation failed
    logic wse_q; // Erase suspended
    logic wsp_q; // Program suspended
    logic otp_mode_q; // Secure sector mode
    logic [6:0] nv_q; // Protection bits mirrored from storage
    logic op_seen_q; // Last opcode toggle consumed
    logic pend_q; // Opcode waiting for its frame to close
    logic [7:0] pend_op_q; // That opcode
    logic req_q; // Snapshot request toggle
    logic [7:0] hold_stat_q; // Status word offered to the link
    logic [7:0] hold_susp_q; // Suspend word offered to the link

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic new_op; // A complete opcode arrived
    logic exec; // Frame closed with opcode pending
    logic exec_set; // Set-latch command takes effect
    logic exec_clr; // Clear-latch command takes effect
    logic busy_bit; // Busy as shown in both bytes
    logic hardware_protect_state; // Hardware protect state
    logic otp_locked; // Secure sector write barred
    logic is_sr; // Status write requested
    logic is_area; // Addressed program or erase
    logic is_chip; // Chip erase
    logic allow; // Request passes every check
    logic grant; // Request accepted this cycle
    logic start_pe; // Program or erase starting
    logic [7:0] status_live; // Current status byte
    logic [7:0] suspend_live; // Current suspend byte
    logic hold_stale; // Offered words out of date

    assign new_op = op_s ^ op_seen_q;
    // Wait for chip select to rise so a longer frame cannot sneak in
    assign exec = pend_q & cs_s;
    assign exec_set = exec & (pend_op_q == `SFW_OP_SET_WL);
    assign exec_clr = exec & (pend_op_q == `SFW_OP_CLR_WL);

    // Suspend and resume cycles count as busy too
    assign busy_bit = busy_q | i_susp_cycle;

    // Pin only matters when the disable bit is clear
    assign hardware_protect_state = nv_q[`SFW_NV_SRP] & ~wp_s & ~nv_q[`SFW_NV_PROTECT_PINS_DISABLE_BIT] & ~otp_mode_q;
    assign otp_locked = otp_mode_q & nv_q[`SFW_NV_OTP];

    assign is_sr = (i_wr_kind == SFW_WK_STATUS);
    // Quad page program follows the plain rules, not the pin bit
    assign is_area = (i_wr_kind == SFW_WK_PAGE) | (i_wr_kind == SFW_WK_SECTOR) | (i_wr_kind == SFW_WK_HALF)
                   | (i_wr_kind == SFW_WK_BLOCK) | (i_wr_kind == SFW_WK_QPAGE);
    assign is_chip = (i_wr_kind == SFW_WK_CHIP);

    // Unknown kinds match no term and are refused
    assign allow = wel_q & ~busy_bit
                 & ((is_sr & ~hardware_protect_state)
                 | (is_area & ~i_target_protected & ~otp_locked)
                 | (is_chip & (nv_q[3:0] == 4'h0) & ~otp_locked));
    assign grant = i_wr_req & allow;
    assign start_pe = grant & ~is_sr;

    // ****************************************************************
    // Byte assembly
    // ****************************************************************
    assign status_live[`SFW_SR_BUSY] = busy_bit;
    assign status_live[`SFW_SR_WEL] = wel_q;
    assign status_live[`SFW_SR_BP_HI:`SFW_SR_BP_LO] = nv_q[3:0];
    assign status_live[`SFW_SR_PROTECT_PINS_DISABLE_BIT] = nv_q[`SFW_NV_PROTECT_PINS_DISABLE_BIT];
    // Same bit position doubles as lock in secure mode
    assign status_live[`SFW_SR_LOCK] = otp_mode_q ? nv_q[`SFW_NV_OTP] : nv_q[`SFW_NV_SRP];

    assign suspend_live = {busy_bit, 1'b0, fail_q, 1'b0, wsp_q, wse_q, wel_q, 1'b0};

    // Offer a new pair only once the link took the last one
    assign hold_stale = (hold_stat_q != status_live) | (hold_susp_q != suspend_live);

    // ****************************************************************
    // Link side
    // ****************************************************************
    sfw_link_shift u_link (
        .i_link_clk(i_link_clk),
        .i_rst(i_sys_rst),
        .i_cs_n(i_cs_n),
        .i_dq_in(i_dq_in),
        .i_quad_mode(i_quad_mode),
        .i_snap_req(req_q),
        .i_hold_status(hold_stat_q),
        .i_hold_suspend(hold_susp_q),
        .o_op_tgl(link_op_tgl),
        .o_opcode(link_opcode),
        .o_snap_ack(link_snap_ack),
        .o_dq_out(o_dq_out),
        .o_dq_oe(o_dq_oe)
    );

    // ****************************************************************
    // Opcode pending until frame end
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            op_seen_q <= 1'b0;
            pend_q <= 1'b0;
            pend_op_q <= 8'h00;
        end else begin
            op_seen_q <= op_s;
            if (new_op) begin
                // Opcode word is stable long before its toggle lands
                pend_q <= 1'b1;
                pend_op_q <= link_opcode;
            end else if (exec) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Write latch; the host command wins over completion
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wel_q <= 1'b0;
        end else if (exec_set) begin
            wel_q <= 1'b1;
        end else if ((exec_clr & ~otp_mode_q) | i_op_done | i_soft_rst) begin
            wel_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Secure sector mode
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            otp_mode_q <= 1'b0;
        end else if (i_otp_enter) begin
            otp_mode_q <= 1'b1;
        end else if ((exec_clr & otp_mode_q) | i_soft_rst) begin
            otp_mode_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Busy flag
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_q <= 1'b0;
        end else if (grant) begin
            busy_q <= 1'b1;
        end else if (i_op_done | i_soft_rst) begin
            busy_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Fail and suspend flags; set beats clear
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fail_q <= 1'b0;
            wse_q <= 1'b0;
            wsp_q <= 1'b0;
        end else begin
            fail_q <= i_op_fail | (fail_q & ~start_pe & ~i_soft_rst);
            wse_q <= i_erase_susp | (wse_q & ~i_erase_resume & ~i_soft_rst);
            wsp_q <= i_prog_susp | (wsp_q & ~i_prog_resume & ~i_soft_rst);
        end
    end

    // ****************************************************************
    // Protection bits: storage load, then status writes
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            nv_q <= `SFW_NV_RST;
        end else if (i_nv_load) begin
            nv_q <= i_nv_bits;
        end else if (grant & is_sr) begin
            if (otp_mode_q) begin
                // Lock only ever goes up; a second set changes nothing
                nv_q[`SFW_NV_OTP] <= nv_q[`SFW_NV_OTP] | i_wr_data[`SFW_SR_LOCK];
            end else begin
                nv_q[5:0] <= i_wr_data[7:2];
            end
        end
    end

    // ****************************************************************
    // Snapshot offer to the link domain
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_q <= 1'b0;
            hold_stat_q <= 8'h00;
            hold_susp_q <= 8'h00;
        end else if ((req_q == ack_s) && hold_stale) begin
            // Hold words frozen while a request is open
            hold_stat_q <= status_live;
            hold_susp_q <= suspend_live;
            req_q <= ~req_q;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wr_grant <= 1'b0;
            o_wr_reject <= 1'b0;
            o_nv_store <= 1'b0;
            o_status_byte <= 8'h00;
            o_suspend_byte <= 8'h00;
            o_otp_mode <= 1'b0;
            o_hw_protect <= 1'b0;
            o_hold_n_eff <= 1'b1;
        end else begin
            o_wr_grant <= grant;
            o_wr_reject <= i_wr_req & ~allow;
            o_nv_store <= grant & is_sr;
            o_status_byte <= status_live;
            o_suspend_byte <= suspend_live;
            o_otp_mode <= otp_mode_q;
            o_hw_protect <= hardware_protect_state;
            // Disabled pins read as released so they may float
            o_hold_n_eff <= nv_q[`SFW_NV_PROTECT_PINS_DISABLE_BIT] | hold_s;
        end
    end

    assign o_nv_bits = nv_q;

endmodule

`default_nettype wire

// file: tb/sfw_write_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks, system clock domain
// ****************************************
module sfw_write_status_chk
    import sfw_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_cs_n,
    input wire logic i_wr_req,
    input wire logic [2:0] i_wr_kind,
    input wire logic i_target_protected,
    input wire logic i_op_done,
    input wire logic i_op_fail,
    input wire logic [3:0] o_dq_oe,
    input wire logic o_wr_grant,
    input wire logic o_wr_reject,
    input wire logic [6:0] o_nv_bits,
    input wire logic [7:0] o_status_byte,
    input wire logic [7:0] o_suspend_byte,
    input wire logic o_hw_protect
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // Both bytes share busy and latch copies
    property p_busy_same; o_status_byte[0] == o_suspend_byte[7]; endproperty
    a_busy_same: assert property (p_busy_same) else $error("busy copies differ");
    property p_wel_same; o_status_byte[1] == o_suspend_byte[1]; endproperty
    a_wel_same: assert property (p_wel_same) else $error("latch copies differ");
    property p_rsvd; (o_suspend_byte & 8'h51) == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved suspend bit set");
    // Every request gets exactly one answer
    property p_reply; i_wr_req |=> o_wr_grant != o_wr_reject; endproperty
    a_reply: assert property (p_reply) else $error("request answer wrong");
    property p_grant_ok; o_wr_grant |-> o_status_byte[1:0] == 2'b10; endproperty
    a_grant_ok: assert property (p_grant_ok) else $error("grant without latch or while busy");
    property p_busy_rise; o_wr_grant |=> o_status_byte[0]; endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy not shown after grant");
    property p_done; i_op_done && !i_wr_req |=> ##1 o_status_byte[1:0] == 2'b00; endproperty
    a_done: assert property (p_done) else $error("completion left latch or busy");
    property p_fail; i_op_fail |=> ##1 o_suspend_byte[5]; endproperty
    a_fail: assert property (p_fail) else $error("fail flag not latched");
    property p_chip; i_wr_req && i_wr_kind == SFW_WK_CHIP && o_nv_bits[3:0] != 4'h0 |=> o_wr_reject; endproperty
    a_chip: assert property (p_chip) else $error("chip erase with protect level");
    property p_prot; i_wr_req && i_target_protected && i_wr_kind inside {SFW_WK_PAGE, SFW_WK_SECTOR,
        SFW_WK_HALF, SFW_WK_BLOCK} |=> o_wr_reject; endproperty
    a_prot: assert property (p_prot) else $error("protected target accepted");
    property p_hwp; i_wr_req && i_wr_kind == SFW_WK_STATUS && o_hw_protect |=> o_wr_reject; endproperty
    a_hwp: assert property (p_hwp) else $error("status write in hardware protect");
    property p_idle; i_cs_n |-> o_dq_oe == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("pins driven outside frame");
endmodule

bind sfw_write_status sfw_write_status_chk u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_cs_n(i_cs_n), .i_wr_req(i_wr_req), .i_wr_kind(i_wr_kind), .i_target_protected(i_target_protected),
    .i_op_done(i_op_done), .i_op_fail(i_op_fail), .o_dq_oe(o_dq_oe), .o_wr_grant(o_wr_grant),
    .o_wr_reject(o_wr_reject), .o_nv_bits(o_nv_bits), .o_status_byte(o_status_byte),
    .o_suspend_byte(o_suspend_byte), .o_hw_protect(o_hw_protect));
`default_nettype wire

// file: tb/sfw_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host controller model, mode 0, 30 ns link clock
// ****************************************
module sfw_host (
    input wire logic [3:0] i_dq_out,
    input wire logic i_quad,
    output logic o_link_clk,
    output logic o_cs_n,
    output logic [3:0] o_dq
);
    initial begin
        o_link_clk = 1'b0;
        o_cs_n = 1'b1;
        o_dq = 4'h5;
    end
    // Idle clocks with select high carry the status copy and mode across; unused lines toggle
    task automatic frame(input logic [7:0] op, input int nop, input int nrd, output logic [15:0] rd);
        logic [7:0] sh;
        sh = op;
        rd = 16'h0000;
        repeat (10) begin
            #15 o_link_clk = 1'b1;
            #15 o_link_clk = 1'b0;
        end
        o_cs_n = 1'b0;
        for (int k = 0; k < nop + nrd; k++) begin
            if (k < nop) begin
                o_dq = i_quad ? sh[7:4] : {~o_dq[3:1], sh[7]};
                sh = i_quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
            end else
                o_dq = ~o_dq;
            #15 o_link_clk = 1'b1;
            if (k >= nop)
                rd = i_quad ? {rd[11:0], i_dq_out} : {rd[14:0], i_dq_out[1]};
            #15 o_link_clk = 1'b0;
        end
        #15 o_cs_n = 1'b1;
        o_dq = ~o_dq;
    endtask
endmodule
`default_nettype wire

// file: tb/test_sfw_write_status.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Test sequence
// ****************************************
module test_sfw_write_status;
    import sfw_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, hold_n = 1'b1, quad = 1'b0, wr_req = 1'b0, tp = 1'b0;
    logic [8:0] pls = 9'h000;
    logic [6:0] nvb = 7'h00;
    logic [2:0] kind = 3'h0;
    logic [7:0] wdata = 8'h00;
    wire logic lclk, cs_n, grant, reject, otp, hwp, hold_eff;
    wire logic [3:0] dq_in, dq_out;
    wire logic [6:0] nv;
    wire logic [7:0] st, ss;
    int num_errors = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    sfw_host u_sfw_host (.i_dq_out(dq_out), .i_quad(quad), .o_link_clk(lclk), .o_cs_n(cs_n), .o_dq(dq_in));
    sfw_write_status u_sfw_write_status (.i_sys_clk(clk), .i_sys_rst(rst), .i_link_clk(lclk), .i_cs_n(cs_n),
        .i_dq_in(dq_in), .o_dq_out(dq_out), .o_dq_oe(), .i_wp_n(wp_n), .i_hold_n(hold_n), .i_quad_mode(quad),
        .i_otp_enter(pls[6]), .i_soft_rst(pls[7]), .i_nv_load(pls[8]), .i_nv_bits(nvb), .i_wr_req(wr_req),
        .i_wr_kind(kind), .i_wr_data(wdata), .i_target_protected(tp), .i_op_done(pls[0]), .i_op_fail(pls[1]),
        .i_susp_cycle(1'b0), .i_erase_susp(pls[2]), .i_erase_resume(pls[3]), .i_prog_susp(pls[4]),
        .i_prog_resume(pls[5]), .o_wr_grant(grant), .o_wr_reject(reject), .o_nv_store(), .o_nv_bits(nv),
        .o_status_byte(st), .o_suspend_byte(ss), .o_otp_mode(otp), .o_hw_protect(hwp), .o_hold_n_eff(hold_eff));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One-cycle pulses on the side-band inputs, then settle
    task automatic pulse(input logic [8:0] m);
        @(negedge clk) pls = m;
        @(negedge clk) pls = 9'h000;
        cyc(3);
    endtask
    // Reply is read twice to see the byte repeat; gap covers the latch sync
    task automatic lnk(input logic [7:0] op, input int nop, input int nrd, input logic [7:0] exp);
        logic [15:0] rd;
        u_sfw_host.frame(op, nop, nrd, rd);
        if (nrd > 0)
            chk(rd, {exp, exp});
        cyc(8);
    endtask
    task automatic req(input logic [2:0] k, input logic t, input logic [7:0] d, input logic g);
        @(negedge clk);
        wr_req = 1'b1;
        kind = k;
        tp = t;
        wdata = d;
        @(negedge clk) wr_req = 1'b0;
        chk({grant, reject}, {g, ~g});
        cyc(3);
    endtask
    initial begin
        #300000;
        num_errors++;
        test_done();
    end
    initial begin
        cyc(10);
        rst = 1'b0;
        cyc(4);
        lnk(8'h05, 8, 16, 8'h00);
        lnk(8'h09, 8, 16, 8'h00);
        req(SFW_WK_PAGE, 1'b0, 8'h00, 1'b0);
        lnk(8'h06, 5, 0, 8'h00);
        chk(st, 8'h00);
        lnk(8'h06, 8, 0, 8'h00);
        chk({st, ss}, 16'h0202);
        lnk(8'h05, 8, 16, 8'h02);
        lnk(8'h04, 8, 0, 8'h00);
        chk(st, 8'h00);
        lnk(8'h06, 8, 0, 8'h00);
        req(SFW_WK_STATUS, 1'b0, 8'h0c, 1'b1);
        chk(nv, 7'h03);
        lnk(8'h05, 8, 16, 8'h0f);
        lnk(8'h09, 8, 16, 8'h82);
        req(SFW_WK_STATUS, 1'b0, 8'h00, 1'b0);
        pulse(9'h001);
        chk(st, 8'h0c);
        lnk(8'h06, 8, 0, 8'h00);
        req(SFW_WK_CHIP, 1'b0, 8'h00, 1'b0);
        req(SFW_WK_SECTOR, 1'b1, 8'h00, 1'b0);
        req(SFW_WK_PAGE, 1'b0, 8'h00, 1'b1);
        pulse(9'h016);
        chk(ss, 8'hae);
        pulse(9'h029);
        chk(ss, 8'h20);
        pulse(9'h080);
        chk(ss, 8'h00);
        lnk(8'h06, 8, 0, 8'h00);
        req(SFW_WK_STATUS, 1'b0, 8'h80, 1'b1);
        pulse(9'h001);
        chk(nv, 7'h20);
        wp_n = 1'b0;
        lnk(8'h06, 8, 0, 8'h00);
        chk(hwp, 1'b1);
        req(SFW_WK_STATUS, 1'b0, 8'h00, 1'b0);
        req(SFW_WK_CHIP, 1'b0, 8'h00, 1'b1);
        pulse(9'h001);
        wp_n = 1'b1;
        hold_n = 1'b0;
        cyc(4);
        chk(hold_eff, 1'b0);
        nvb = 7'h10;
        pulse(9'h100);
        chk(hold_eff, 1'b1);
        hold_n = 1'b1;
        quad = 1'b1;
        cyc(4);
        lnk(8'h06, 2, 0, 8'h00);
        lnk(8'h05, 2, 4, 8'h42);
        lnk(8'h09, 2, 4, 8'h02);
        lnk(8'h04, 2, 0, 8'h00);
        chk(st, 8'h40);
        quad = 1'b0;
        pulse(9'h040);
        chk(otp, 1'b1);
        lnk(8'h06, 8, 0, 8'h00);
        req(SFW_WK_STATUS, 1'b0, 8'h80, 1'b1);
        chk(st, 8'hc3);
        lnk(8'h04, 8, 0, 8'h00);
        chk(otp, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
